// ---- hdl/tofc_pkg.sv ----
// Package: register map, field positions and state layout of the timer control
package tofc_pkg;

    // ----------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] TOFC_CTRL_OFFS   = 8'h00;
    localparam logic [7:0] TOFC_MODE_OFFS   = 8'h04;
    localparam logic [7:0] TOFC_EVENT_OFFS  = 8'h08;
    localparam logic [7:0] TOFC_MASK_OFFS   = 8'h0c;
    localparam logic [7:0] TOFC_LOW0_OFFS   = 8'h10;
    localparam logic [7:0] TOFC_LOW1_OFFS   = 8'h14;
    localparam logic [7:0] TOFC_RELOAD0_OFFS = 8'h18;
    localparam logic [7:0] TOFC_RELOAD1_OFFS = 8'h1c;

    // ----------------------------------------
    // Control register fields
    // ----------------------------------------
    localparam int TOFC_SECOND_FLAG_BIT = 7;
    localparam int TOFC_SECOND_RUN_BIT  = 6;
    localparam int TOFC_FIRST_FLAG_BIT  = 5;
    localparam int TOFC_FIRST_RUN_BIT   = 4;

    // Mode register fields: gate enables
    localparam int TOFC_FIRST_GATE_BIT  = 0;
    localparam int TOFC_SECOND_GATE_BIT = 1;

    // ----------------------------------------
    // Reset values and count limit
    // ----------------------------------------
    localparam logic [7:0] TOFC_CTRL_RST   = 8'h00;
    localparam logic [1:0] TOFC_MODE_RST   = 2'h0;
    localparam logic [1:0] TOFC_MASK_RST   = 2'h0;
    localparam logic [7:0] TOFC_COUNT_RST  = 8'h00;
    localparam logic [7:0] TOFC_COUNT_MAX  = 8'hff;

    // ----------------------------------------
    // Types
    // ----------------------------------------
    typedef struct packed {
        logic [1:0] run;      // Index 0 first timer, 1 second timer
        logic [1:0] flag;
        logic [1:0] gate;
        logic [1:0] evt;      // Sticky overflow events for interrupt
        logic [1:0] mask;
        logic [7:0] low0;
        logic [7:0] low1;
        logic [7:0] reload0;
        logic [7:0] reload1;
        logic [31:0] rdata;
    } tofc_state_t;

    typedef struct packed {
        logic [1:0] enable;
        logic [1:0] overflow;
    } tofc_tick_t;

endpackage

// ---- hdl/tofc_counter.sv ----
// Eight-bit auto-reload counter with overflow pulse
`timescale 1ns/1ps
module tofc_counter
    import tofc_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rstSync_n,
    // Control
    input  wire logic             enable,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] loadValue,
    input  wire logic [WIDTH-1:0] reloadValue,
    // Status
    output logic      [WIDTH-1:0] count,
    output logic                  overflow
);

    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic             wrap;

    // ----------------------------------------
    // Counting
    // ----------------------------------------
    // Leaving all ones is the overflow; the low byte reloads from reloadValue
    assign wrap = enable && (count_reg == {WIDTH{1'b1}});

    always_comb begin
        count_next = count_reg;
        if (load) begin
            count_next = loadValue;
        end else if (wrap) begin
            count_next = reloadValue;
        end else if (enable) begin
            count_next = count_reg + 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    assign count    = count_reg;
    assign overflow = wrap && !load;

endmodule

// ---- hdl/tofc_timer_control.sv ----
// Timer run control and overflow flags with APB registers
// Functional notes
// - Second timer overflow sets its flag
// - Second flag clears on vector or write
// - First timer overflow sets its flag
// - First flag clears on vector or write
// - Ungated first timer runs on run bit
// - Ungated second timer runs on run bit
// - Low byte wrap from all ones to the reload value is overflow
`timescale 1ns/1ps
module tofc_timer_control
    import tofc_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Gate pins and CPU vector acknowledges
    input  wire logic        firstExternalGateInput,
    input  wire logic        secondExternalGateInput,
    input  wire logic        firstVectorAck,
    input  wire logic        secondVectorAck,
    // Timer status
    output logic             firstTimerOverflowFlag,
    output logic             secondTimerOverflowFlag,
    output logic             firstTimerEnabled,
    output logic             secondTimerEnabled,
    output logic             irq
);

    // ----------------------------------------
    // Reset and pin synchronisers
    // ----------------------------------------
    logic [1:0]  rstPipe;
    logic        rstSync_n;
    logic [1:0]  gateMeta;
    logic [1:0]  gateSync;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rstPipe <= 2'h0;
        end else begin
            rstPipe <= {rstPipe[0], 1'b1};
        end
    end
    assign rstSync_n = rstPipe[1];

    // Gate pins are asynchronous; only the second stage is read
    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            gateMeta <= 2'h0;
            gateSync <= 2'h0;
        end else begin
            gateMeta <= {secondExternalGateInput, firstExternalGateInput};
            gateSync <= gateMeta;
        end
    end

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    tofc_state_t state_reg;
    tofc_state_t state_next;
    tofc_tick_t  tick;
    logic        wrEn;
    logic        rdEn;
    logic        mapped;
    logic [7:0]  ctrlView;
    logic [7:0]  count0;
    logic [7:0]  count1;
    logic        load0;
    logic        load1;

    // Zero wait states: every access completes in its first access cycle
    assign wrEn = psel && penable && pwrite;
    assign rdEn = psel && penable && !pwrite;
    assign mapped = (paddr == TOFC_CTRL_OFFS) || (paddr == TOFC_MODE_OFFS)
                 || (paddr == TOFC_EVENT_OFFS) || (paddr == TOFC_MASK_OFFS)
                 || (paddr == TOFC_LOW0_OFFS) || (paddr == TOFC_LOW1_OFFS)
                 || (paddr == TOFC_RELOAD0_OFFS)
                 || (paddr == TOFC_RELOAD1_OFFS);
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign load0 = wrEn && (paddr == TOFC_LOW0_OFFS);
    assign load1 = wrEn && (paddr == TOFC_LOW1_OFFS);

    // ----------------------------------------
    // Run enables
    // ----------------------------------------
    // Gate off: the run bit alone decides; gate on: pin must also be high
    for (genvar i = 0; i < 2; i++) begin : g_enable
        assign tick.enable[i] = state_reg.run[i]
                             && (!state_reg.gate[i] || gateSync[i]);
    end

    tofc_counter #(
        .WIDTH       (8)
    ) u_counter0 (
        .clock       (clock),
        .rstSync_n   (rstSync_n),
        .enable      (tick.enable[0]),
        .load        (load0),
        .loadValue   (pwdata[7:0]),
        .reloadValue (state_reg.reload0),
        .count       (count0),
        .overflow    (tick.overflow[0])
    );

    tofc_counter #(
        .WIDTH       (8)
    ) u_counter1 (
        .clock       (clock),
        .rstSync_n   (rstSync_n),
        .enable      (tick.enable[1]),
        .load        (load1),
        .loadValue   (pwdata[7:0]),
        .reloadValue (state_reg.reload1),
        .count       (count1),
        .overflow    (tick.overflow[1])
    );

    assign ctrlView = {state_reg.flag[1], state_reg.run[1],
                       state_reg.flag[0], state_reg.run[0], 4'h0};

    // ----------------------------------------
    // State update
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.low0 = count0;
        state_next.low1 = count1;
        if (wrEn) begin
            case (paddr)
                TOFC_CTRL_OFFS: begin
                    state_next.run[0]  = pwdata[TOFC_FIRST_RUN_BIT];
                    state_next.run[1]  = pwdata[TOFC_SECOND_RUN_BIT];
                    state_next.flag[0] = pwdata[TOFC_FIRST_FLAG_BIT];
                    state_next.flag[1] = pwdata[TOFC_SECOND_FLAG_BIT];
                end
                TOFC_MODE_OFFS: begin
                    state_next.gate[0] = pwdata[TOFC_FIRST_GATE_BIT];
                    state_next.gate[1] = pwdata[TOFC_SECOND_GATE_BIT];
                end
                TOFC_MASK_OFFS:    state_next.mask    = pwdata[1:0];
                TOFC_RELOAD0_OFFS: state_next.reload0 = pwdata[7:0];
                TOFC_RELOAD1_OFFS: state_next.reload1 = pwdata[7:0];
                default: ;
            endcase
        end
        // Vector acknowledge clears the flag
        if (firstVectorAck) begin
            state_next.flag[0] = 1'b0;
        end
        if (secondVectorAck) begin
            state_next.flag[1] = 1'b0;
        end
        // Reading the event register clears it
        // Only events already shown are cleared; a later one stays pending
        if (rdEn && (paddr == TOFC_EVENT_OFFS)) begin
            state_next.evt = state_reg.evt & ~state_reg.rdata[1:0];
        end
        // Overflow comes last so a same-cycle clear never loses it
        if (tick.overflow[0]) begin
            state_next.flag[0] = 1'b1;
            state_next.evt[0]  = 1'b1;
        end
        if (tick.overflow[1]) begin
            state_next.flag[1] = 1'b1;
            state_next.evt[1]  = 1'b1;
        end
        state_next.rdata = 32'h0;
        case (paddr)
            TOFC_CTRL_OFFS:    state_next.rdata = {24'h0, ctrlView};
            TOFC_MODE_OFFS:    state_next.rdata = {30'h0, state_reg.gate};
            TOFC_EVENT_OFFS:   state_next.rdata = {30'h0, state_reg.evt};
            TOFC_MASK_OFFS:    state_next.rdata = {30'h0, state_reg.mask};
            TOFC_LOW0_OFFS:    state_next.rdata = {24'h0, count0};
            TOFC_LOW1_OFFS:    state_next.rdata = {24'h0, count1};
            TOFC_RELOAD0_OFFS: state_next.rdata = {24'h0, state_reg.reload0};
            TOFC_RELOAD1_OFFS: state_next.rdata = {24'h0, state_reg.reload1};
            default:           state_next.rdata = 32'h0;
        endcase
        // Captured in the setup cycle so the access cycle reads a flop
        if (!(psel && !penable && !pwrite)) begin
            state_next.rdata = 32'h0;
        end
    end

    always_ff @(posedge clock or negedge rstSync_n) begin
        if (!rstSync_n) begin
            state_reg         <= '0;
            state_reg.mask    <= TOFC_MASK_RST;
            state_reg.gate    <= TOFC_MODE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    // Read data stands from a flop through the access cycle, zero wait
    assign prdata = state_reg.rdata;

    assign firstTimerOverflowFlag  = state_reg.flag[0];
    assign secondTimerOverflowFlag = state_reg.flag[1];
    assign firstTimerEnabled       = tick.enable[0];
    assign secondTimerEnabled      = tick.enable[1];
    assign irq = |(state_reg.evt & state_reg.mask);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_first_set;
        @(posedge clock) disable iff (!rstSync_n)
        tick.overflow[0] |=> firstTimerOverflowFlag;
    endproperty
    a_first_set: assert property (p_first_set)
        else $error("first flag not set after overflow");

    property p_second_set;
        @(posedge clock) disable iff (!rstSync_n)
        tick.overflow[1] |=> secondTimerOverflowFlag;
    endproperty
    a_second_set: assert property (p_second_set)
        else $error("second flag not set after overflow");

    property p_first_ack;
        @(posedge clock) disable iff (!rstSync_n)
        (firstVectorAck && !tick.overflow[0]) |=> !firstTimerOverflowFlag;
    endproperty
    a_first_ack: assert property (p_first_ack)
        else $error("first flag not cleared by vector");

    property p_second_ack;
        @(posedge clock) disable iff (!rstSync_n)
        (secondVectorAck && !tick.overflow[1]) |=> !secondTimerOverflowFlag;
    endproperty
    a_second_ack: assert property (p_second_ack)
        else $error("second flag not cleared by vector");

    property p_first_run;
        @(posedge clock) disable iff (!rstSync_n)
        (state_reg.run[0] && !state_reg.gate[0]) |-> firstTimerEnabled;
    endproperty
    a_first_run: assert property (p_first_run)
        else $error("ungated first timer not enabled");

    property p_second_run;
        @(posedge clock) disable iff (!rstSync_n)
        (state_reg.run[1] && !state_reg.gate[1]) |-> secondTimerEnabled;
    endproperty
    a_second_run: assert property (p_second_run)
        else $error("ungated second timer not enabled");

    property p_wrap;
        @(posedge clock) disable iff (!rstSync_n)
        (firstTimerEnabled && count0 == TOFC_COUNT_MAX && !load0)
            |=> (count0 == $past(state_reg.reload0)) && firstTimerOverflowFlag;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("wrap did not reload and flag");

    property p_set_wins;
        @(posedge clock) disable iff (!rstSync_n)
        (tick.overflow[0] && wrEn && paddr == TOFC_CTRL_OFFS
            && !pwdata[TOFC_FIRST_FLAG_BIT]) |=> firstTimerOverflowFlag;
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("software clear beat overflow");

    property p_second_set_wins;
        @(posedge clock) disable iff (!rstSync_n)
        (tick.overflow[1] && wrEn && paddr == TOFC_CTRL_OFFS
            && !pwdata[TOFC_SECOND_FLAG_BIT]) |=> secondTimerOverflowFlag;
    endproperty
    a_second_set_wins: assert property (p_second_set_wins)
        else $error("software clear beat second overflow");

    property p_first_sw_clear;
        @(posedge clock) disable iff (!rstSync_n)
        (wrEn && paddr == TOFC_CTRL_OFFS && !pwdata[TOFC_FIRST_FLAG_BIT]
            && !tick.overflow[0]) |=> !firstTimerOverflowFlag;
    endproperty
    a_first_sw_clear: assert property (p_first_sw_clear)
        else $error("first flag not cleared by write");

    property p_second_sw_clear;
        @(posedge clock) disable iff (!rstSync_n)
        (wrEn && paddr == TOFC_CTRL_OFFS && !pwdata[TOFC_SECOND_FLAG_BIT]
            && !tick.overflow[1]) |=> !secondTimerOverflowFlag;
    endproperty
    a_second_sw_clear: assert property (p_second_sw_clear)
        else $error("second flag not cleared by write");

    property p_second_wrap;
        @(posedge clock) disable iff (!rstSync_n)
        (secondTimerEnabled && count1 == TOFC_COUNT_MAX && !load1)
            |=> (count1 == $past(state_reg.reload1)) && secondTimerOverflowFlag;
    endproperty
    a_second_wrap: assert property (p_second_wrap)
        else $error("second wrap did not reload and flag");

endmodule

// ---- test/tofc_cpu_model.sv ----
// CPU vectoring model: answers a bench request with a vector acknowledge
`timescale 1ns/1ps
module tofc_cpu_model (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst_n,
    // Requests from the bench
    input  wire logic [1:0] vectorReq,
    input  wire logic       slow,
    // Vector acknowledges towards the device
    output logic      [1:0] vectorAck
);
    logic [1:0] pendReg;
    logic [1:0] waitReg;

    // ----------------------------------------
    // Vector latency and one-cycle acknowledge
    // ----------------------------------------
    // Slow mode models a CPU finishing a long instruction before vectoring
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pendReg   <= 2'h0;
            waitReg   <= 2'h0;
            vectorAck <= 2'h0;
        end else begin
            vectorAck <= 2'h0;
            if (vectorReq != 2'h0) begin
                pendReg <= vectorReq;
                waitReg <= slow ? 2'h3 : 2'h0;
            end else if (pendReg != 2'h0 && waitReg != 2'h0) begin
                waitReg <= waitReg - 2'h1;
            end else if (pendReg != 2'h0) begin
                vectorAck <= pendReg;
                pendReg   <= 2'h0;
            end
        end
    end
endmodule

// ---- test/test_timer_overflow_flag_control.sv ----
// Register-level testbench of the timer run control and overflow flags
`timescale 1ns/1ps
module test_timer_overflow_flag_control;
    import tofc_pkg::*;
    logic        clock;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  gatePin;
    logic [1:0]  vectorReq;
    logic        slow;
    logic [1:0]  vectorAck;
    logic [1:0]  flags;
    logic [1:0]  enabled;
    logic        irq;
    logic [31:0] runM;
    logic [31:0] flagM;
    logic [7:0]  lowA;
    logic [7:0]  relA;
    logic [31:0] rq;
    logic        re;
    int          n_fail;
    int          n_tests;

    tofc_timer_control uut (
        .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .firstExternalGateInput(gatePin[0]),
        .secondExternalGateInput(gatePin[1]),
        .firstVectorAck(vectorAck[0]), .secondVectorAck(vectorAck[1]),
        .firstTimerOverflowFlag(flags[0]),
        .secondTimerOverflowFlag(flags[1]),
        .firstTimerEnabled(enabled[0]), .secondTimerEnabled(enabled[1]),
        .irq(irq));
    tofc_cpu_model cpu (.clock(clock), .rst_n(rst_n), .vectorReq(vectorReq),
        .slow(slow), .vectorAck(vectorAck));

    always #20 clock = ~clock;

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic end_of_test();
        if (n_fail == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Request is held until pready is seen high; no latency is assumed
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rq = prdata;
        re = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) begin
            n_fail++;
            end_of_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        check(rq, x);
    endtask

    task automatic wait_flag(input int i, input logic v);
        int k;
        k = 0;
        while (flags[i] !== v && k < 300) begin
            @(posedge clock);
            #1;
            k++;
        end
        if (k >= 300) begin
            n_fail++;
            end_of_test();
        end
    endtask

    task automatic ack(input int i);
        @(posedge clock);
        vectorReq <= 2'(1 << i);
        slow      <= (i == 1);
        @(posedge clock);
        vectorReq <= 2'h0;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        clock = 1'b0; rst_n = 1'b0; psel = 1'b0; penable = 1'b0;
        pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; gatePin = 2'h0;
        vectorReq = 2'h0; slow = 1'b0; n_fail = 0; n_tests = 0;
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        repeat (3) @(posedge clock);
        rd(TOFC_CTRL_OFFS, 32'h0);
        rd(TOFC_MODE_OFFS, 32'h0);
        rd(TOFC_MASK_OFFS, 32'h0);
        rd(TOFC_EVENT_OFFS, 32'h0);
        rd(8'h20, 32'h0);
        check({31'h0, re}, 32'h1);
        // Run bits with gating off, then gated by the pins
        wr(TOFC_CTRL_OFFS, 32'h50);
        #1 check({30'h0, enabled}, 32'h3);
        rd(TOFC_CTRL_OFFS, 32'h50);
        wr(TOFC_MODE_OFFS, 32'h3);
        #1 check({30'h0, enabled}, 32'h0);
        @(posedge clock) gatePin <= 2'h3;
        repeat (4) @(posedge clock);
        #1 check({30'h0, enabled}, 32'h3);
        gatePin <= 2'h0;
        wr(TOFC_CTRL_OFFS, 32'h0);
        wr(TOFC_MODE_OFFS, 32'h0);
        for (int i = 0; i < 2; i++) begin
            runM  = 32'(1) << (i ? TOFC_SECOND_RUN_BIT : TOFC_FIRST_RUN_BIT);
            flagM = 32'(1) << (i ? TOFC_SECOND_FLAG_BIT : TOFC_FIRST_FLAG_BIT);
            lowA  = i ? TOFC_LOW1_OFFS : TOFC_LOW0_OFFS;
            relA  = i ? TOFC_RELOAD1_OFFS : TOFC_RELOAD0_OFFS;
            // Wrap from all ones to the reload value sets the flag and the event
            wr(relA, 32'h80);
            rd(relA, 32'h80);
            wr(lowA, 32'hfd);
            wr(TOFC_CTRL_OFFS, runM);
            wait_flag(i, 1'b1);
            rd(TOFC_CTRL_OFFS, runM | flagM);
            wr(TOFC_CTRL_OFFS, flagM);
            rd(TOFC_CTRL_OFFS, flagM);
            #1 check({31'h0, irq}, 32'h0);
            wr(TOFC_MASK_OFFS, 32'(1 << i));
            #1 check({31'h0, irq}, 32'h1);
            rd(TOFC_EVENT_OFFS, 32'(1 << i));
            #1 check({31'h0, irq}, 32'h0);
            // Vector clear, then software set and clear
            ack(i);
            wait_flag(i, 1'b0);
            rd(TOFC_CTRL_OFFS, 32'h0);
            wr(TOFC_CTRL_OFFS, flagM);
            rd(TOFC_CTRL_OFFS, flagM);
            wr(TOFC_CTRL_OFFS, 32'h0);
            rd(TOFC_CTRL_OFFS, 32'h0);
            // Reload of all ones overflows every cycle: clears collide
            wr(relA, 32'hff);
            wr(lowA, 32'hff);
            wr(TOFC_CTRL_OFFS, runM);
            wr(TOFC_CTRL_OFFS, runM);
            #1 check({31'h0, flags[i]}, 32'h1);
            ack(i);
            repeat (8) begin
                @(posedge clock);
                #1 check({31'h0, flags[i]}, 32'h1);
            end
            wr(TOFC_CTRL_OFFS, 32'h0);
            wr(TOFC_CTRL_OFFS, 32'h0);
            rd(TOFC_CTRL_OFFS, 32'h0);
            rd(lowA, 32'hff);
            rd(relA, 32'hff);
            rd(TOFC_EVENT_OFFS, 32'(1 << i));
            wr(TOFC_MASK_OFFS, 32'h0);
        end
        end_of_test();
    end
endmodule
